// ---- bpdi_pkg.sv ----
/*
 * Constants, register map and state types for the page-boundary and
 * doorbell interrupt block of the bridge.
 * Assumes a single pclk domain and an APB register port.
 */
package bpdi_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus and field widths
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int PAGE_W   = 7;
    localparam int PIDX_W   = 5;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_PB_REQ_HI  = 12'h05C;
    localparam logic [ADDR_W-1:0] OFF_PB_MASK_LO = 12'h060;
    localparam logic [ADDR_W-1:0] OFF_PB_MASK_HI = 12'h064;
    localparam logic [ADDR_W-1:0] OFF_DB_CLEAR   = 12'h070;
    localparam logic [ADDR_W-1:0] OFF_DB_SET     = 12'h074;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [DATA_W-1:0] RST_PB_REQ  = 32'h00000000;
    localparam logic [DATA_W-1:0] RST_PB_MASK = 32'h0FFFFFFF;
    localparam logic [DATA_W-1:0] RST_DB      = 32'h00000000;
    localparam logic [DATA_W-1:0] RD_ZERO     = 32'h00000000;
    localparam logic [DATA_W-1:0] BIT0        = 32'h00000001;

    ////////////////////////////////////////////////////////////////////////
    // Doorbell halves and page range of the upper request register
    localparam int DB_PRI_LSB = 0;
    localparam int DB_PRI_MSB = 15;
    localparam int DB_SEC_LSB = 16;
    localparam int DB_SEC_MSB = 31;
    localparam logic [PAGE_W-1:0] PAGE_HI_FIRST = 7'h21;
    localparam logic [PAGE_W-1:0] PAGE_HI_LAST  = 7'h40;

    ////////////////////////////////////////////////////////////////////////
    // State of the register block
    typedef struct packed {
        logic [DATA_W-1:0] pb_req_hi;
        logic [DATA_W-1:0] pb_mask_lo;
        logic [DATA_W-1:0] pb_mask_hi;
        logic [DATA_W-1:0] db;
        logic [DATA_W-1:0] prdata;
        logic              slverr;
        logic              rev_s1;
        logic              rev_s2;
        logic              msi_s1;
        logic              msi_s2;
    } bpdi_state_type;

    // State of one interrupt signalling end
    typedef struct packed {
        logic req_d;
        logic intx_n;
        logic msg_assert;
        logic msg_deassert;
        logic msi_req;
    } bpdi_out_state_type;

endpackage

// ---- bpdi_irq_out.sv ----
/*
 * One interrupt signalling end: turns a request level into an INTx pin
 * level, assert and deassert message pulses, or an MSI pulse.
 * Assumes mode inputs already synchronised to pclk.
 */
`timescale 1ns/100ps
module bpdi_irq_out (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic req,
    input  wire logic on_pci,
    input  wire logic msi_en,
    output logic      intx_n,
    output logic      msg_assert,
    output logic      msg_deassert,
    output logic      msi_req
);

    ////////////////////////////////////////////////////////////////////////
    localparam bpdi_pkg::bpdi_out_state_type OUT_RESET = '{
        req_d: 1'b0, intx_n: 1'b1, msg_assert: 1'b0,
        msg_deassert: 1'b0, msi_req: 1'b0};

    bpdi_pkg::bpdi_out_state_type st_r;
    bpdi_pkg::bpdi_out_state_type st_nxt;
    logic                         rise;
    logic                         fall;
    logic                         use_msg;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt       = st_r;
        rise         = req & ~st_r.req_d;
        fall         = ~req & st_r.req_d;
        use_msg      = ~on_pci & ~msi_en;
        st_nxt.req_d = req;
        // Pin on the conventional bus side
        st_nxt.intx_n       = ~(req & on_pci & ~msi_en);
        // Messages on the serial link side
        st_nxt.msg_assert   = rise & use_msg;
        st_nxt.msg_deassert = fall & use_msg;
        st_nxt.msi_req      = rise & msi_en;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= OUT_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign intx_n       = st_r.intx_n;
    assign msg_assert   = st_r.msg_assert;
    assign msg_deassert = st_r.msg_deassert;
    assign msi_req      = st_r.msi_req;

endmodule

// ---- bpdi_irq_ctrl.sv ----
/*
 * Page-boundary and doorbell interrupt request registers of the bridge,
 * with APB register port and primary and secondary signalling ends.
 * Assumes transfer-done strobes come from logic on pclk; the bridge
 * direction and MSI enable come from pins and are synchronised here.
 */
// The implementer's own choice: register access over APB.
// Overview of operation
// RULE1: A 32-bit request register holds pages 33 (bit 0) to 64 (bit 31).
// RULE2: A completed transfer covering a page's last dword sets its bit.
// RULE3: An unmasked set page bit raises the secondary interrupt.
// RULE4: As a forward bridge the secondary side uses INTA pin or MSI.
// RULE5: As a reverse bridge the secondary side uses messages or MSI.
// RULE6: Writing one clears a page bit; page bits reset to zero.
// RULE7: A mask bit of zero passes its page, one blocks; masks reset high (the code resets both masks to 0FFFFFFF, so bits 31:28 pass).
// RULE8: Writing one to the clear word clears that doorbell bit.
// RULE9: Writing one to the set word sets that doorbell bit.
// RULE10: Both doorbell words read the current bits, which reset to zero.
// RULE11: Low doorbell half goes to primary, high half to secondary.
// RULE12: Writing zero to any request bit leaves it unchanged.
// RULE13: Set and clear words share one set of doorbell flops.
`timescale 1ns/100ps
module bpdi_irq_ctrl (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [bpdi_pkg::ADDR_W-1:0] paddr,
    input  wire logic [bpdi_pkg::DATA_W-1:0] pwdata,
    output logic      [bpdi_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        xfer_done,
    input  wire logic                        xfer_last_dw,
    input  wire logic [bpdi_pkg::PAGE_W-1:0] xfer_page,
    input  wire logic                        bridge_reverse,
    input  wire logic                        msi_enable,
    output logic                             pri_intx_n,
    output logic                             pri_msg_assert,
    output logic                             pri_msg_deassert,
    output logic                             pri_msi_req,
    output logic                             sec_intx_n,
    output logic                             sec_msg_assert,
    output logic                             sec_msg_deassert,
    output logic                             sec_msi_req,
    output logic                             irq
);

    ////////////////////////////////////////////////////////////////////////
    localparam bpdi_pkg::bpdi_state_type ST_RESET = '{
        pb_req_hi:  bpdi_pkg::RST_PB_REQ,
        pb_mask_lo: bpdi_pkg::RST_PB_MASK,
        pb_mask_hi: bpdi_pkg::RST_PB_MASK,
        db:         bpdi_pkg::RST_DB,
        prdata:     bpdi_pkg::RD_ZERO,
        slverr:     1'b0,
        rev_s1:     1'b0,
        rev_s2:     1'b0,
        msi_s1:     1'b0,
        msi_s2:     1'b0};

    bpdi_pkg::bpdi_state_type        st_r;
    bpdi_pkg::bpdi_state_type        st_nxt;
    logic                            setup;
    logic                            wr;
    logic [bpdi_pkg::PIDX_W-1:0]     page_idx;
    logic                            page_hit;
    logic [bpdi_pkg::DATA_W-1:0]     page_set;
    logic [bpdi_pkg::DATA_W-1:0]     page_clr;
    logic                            pri_req;
    logic                            sec_req;

    ////////////////////////////////////////////////////////////////////////
    // Word-aligned address match
    function automatic logic hit(
        input logic [bpdi_pkg::ADDR_W-1:0] a,
        input logic [bpdi_pkg::ADDR_W-1:0] off
    );
        return a[bpdi_pkg::ADDR_W-1:2] == off[bpdi_pkg::ADDR_W-1:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt   = st_r;
        setup    = psel & ~penable;
        wr       = psel & penable & pwrite;
        page_idx = bpdi_pkg::PIDX_W'(xfer_page - bpdi_pkg::PAGE_HI_FIRST);
        page_hit = xfer_done & xfer_last_dw
                 & (xfer_page >= bpdi_pkg::PAGE_HI_FIRST)
                 & (xfer_page <= bpdi_pkg::PAGE_HI_LAST);
        page_set = page_hit ? (bpdi_pkg::BIT0 << page_idx) //RULE2
                            : bpdi_pkg::RD_ZERO;
        page_clr = (wr && hit(paddr, bpdi_pkg::OFF_PB_REQ_HI))
                 ? pwdata : bpdi_pkg::RD_ZERO; //RULE12

        // Pin synchronisers
        st_nxt.rev_s1 = bridge_reverse;
        st_nxt.rev_s2 = st_r.rev_s1;
        st_nxt.msi_s1 = msi_enable;
        st_nxt.msi_s2 = st_r.msi_s1;

        // Page requests, hardware set wins over clear
        st_nxt.pb_req_hi = (st_r.pb_req_hi & ~page_clr) | page_set; //RULE6

        // Masks
        if (wr && hit(paddr, bpdi_pkg::OFF_PB_MASK_LO)) begin
            st_nxt.pb_mask_lo = pwdata; //RULE7
        end
        if (wr && hit(paddr, bpdi_pkg::OFF_PB_MASK_HI)) begin
            st_nxt.pb_mask_hi = pwdata; //RULE7
        end

        // Doorbells, one shared flop set
        if (wr && hit(paddr, bpdi_pkg::OFF_DB_SET)) begin
            st_nxt.db = st_r.db | pwdata; //RULE9 RULE13
        end
        if (wr && hit(paddr, bpdi_pkg::OFF_DB_CLEAR)) begin
            st_nxt.db = st_r.db & ~pwdata; //RULE8 RULE13
        end

        // Read data captured in the setup cycle
        if (setup) begin
            st_nxt.slverr = 1'b0;
            if (hit(paddr, bpdi_pkg::OFF_PB_REQ_HI)) begin
                st_nxt.prdata = st_r.pb_req_hi; //RULE1
            end else if (hit(paddr, bpdi_pkg::OFF_PB_MASK_LO)) begin
                st_nxt.prdata = st_r.pb_mask_lo;
            end else if (hit(paddr, bpdi_pkg::OFF_PB_MASK_HI)) begin
                st_nxt.prdata = st_r.pb_mask_hi;
            end else if (hit(paddr, bpdi_pkg::OFF_DB_CLEAR)
                      || hit(paddr, bpdi_pkg::OFF_DB_SET)) begin
                st_nxt.prdata = st_r.db; //RULE10
            end else begin
                st_nxt.prdata = bpdi_pkg::RD_ZERO;
                st_nxt.slverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus outputs
    assign prdata  = st_r.prdata;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & st_r.slverr;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt requests per side
    assign pri_req = |st_r.db[bpdi_pkg::DB_PRI_MSB:bpdi_pkg::DB_PRI_LSB];
    assign sec_req = (|(st_r.pb_req_hi & ~st_r.pb_mask_hi)) //RULE3 RULE7
                   | (|st_r.db[bpdi_pkg::DB_SEC_MSB:bpdi_pkg::DB_SEC_LSB]);
    assign irq     = pri_req | sec_req; //RULE11

    // Primary faces the conventional bus only in reverse mode
    bpdi_irq_out u_pri (
        .pclk         (pclk),
        .presetn      (presetn),
        .req          (pri_req),
        .on_pci       (st_r.rev_s2),
        .msi_en       (st_r.msi_s2),
        .intx_n       (pri_intx_n),
        .msg_assert   (pri_msg_assert),
        .msg_deassert (pri_msg_deassert),
        .msi_req      (pri_msi_req)
    );

    // Secondary faces the conventional bus in forward mode
    bpdi_irq_out u_sec (
        .pclk         (pclk),
        .presetn      (presetn),
        .req          (sec_req),
        .on_pci       (~st_r.rev_s2), //RULE4 RULE5
        .msi_en       (st_r.msi_s2),
        .intx_n       (sec_intx_n),
        .msg_assert   (sec_msg_assert),
        .msg_deassert (sec_msg_deassert),
        .msi_req      (sec_msi_req)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wr_to(logic [bpdi_pkg::ADDR_W-1:0] off);
        wr && hit(paddr, off);
    endsequence

    sequence s_sec_pin_low;
        ##[1:2] !sec_intx_n;
    endsequence

    property p_page_set;
        page_hit |=> ((st_r.pb_req_hi & $past(page_set)) == $past(page_set));
    endproperty
    a_page_set: assert property (p_page_set) //RULE2
        else $error("page request bit not set after transfer");

    property p_page_clr;
        s_wr_to(bpdi_pkg::OFF_PB_REQ_HI) ##0 !page_hit
        |=> ((st_r.pb_req_hi & $past(pwdata)) == bpdi_pkg::RD_ZERO);
    endproperty
    a_page_clr: assert property (p_page_clr) //RULE6
        else $error("page request bit not cleared by write of one");

    property p_zero_keeps;
        s_wr_to(bpdi_pkg::OFF_PB_REQ_HI)
        |=> (((st_r.pb_req_hi ^ $past(st_r.pb_req_hi))
             & ~$past(pwdata) & ~$past(page_set)) == bpdi_pkg::RD_ZERO);
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) //RULE12
        else $error("page request bit changed by write of zero");

    property p_fwd_pin;
        ((st_r.pb_req_hi & ~st_r.pb_mask_hi) != bpdi_pkg::RD_ZERO)
        && !st_r.rev_s2 && !st_r.msi_s2 && $stable(st_r.rev_s2)
        && $stable(st_r.msi_s2) |-> s_sec_pin_low;
    endproperty
    a_fwd_pin: assert property (p_fwd_pin) //RULE3 RULE4
        else $error("secondary pin not asserted for page request");

    property p_rev_msg;
        $rose(sec_req) && st_r.rev_s2 && !st_r.msi_s2
        |=> sec_msg_assert && sec_intx_n;
    endproperty
    a_rev_msg: assert property (p_rev_msg) //RULE5
        else $error("no assert message in reverse mode");

    property p_masked_quiet;
        ((st_r.pb_req_hi & ~st_r.pb_mask_hi) == bpdi_pkg::RD_ZERO)
        && (st_r.db[bpdi_pkg::DB_SEC_MSB:bpdi_pkg::DB_SEC_LSB] == 16'h0000)
        |=> sec_intx_n;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) //RULE7
        else $error("secondary pin asserted with all requests masked");

    property p_db_set;
        s_wr_to(bpdi_pkg::OFF_DB_SET)
        |=> ((st_r.db & $past(pwdata)) == $past(pwdata));
    endproperty
    a_db_set: assert property (p_db_set) //RULE9
        else $error("doorbell bit not set by write of one");

    property p_db_clr;
        s_wr_to(bpdi_pkg::OFF_DB_CLEAR)
        |=> ((st_r.db & $past(pwdata)) == bpdi_pkg::RD_ZERO)
            && ((st_r.db & ~$past(pwdata)) == ($past(st_r.db)
                & ~$past(pwdata)));
    endproperty
    a_db_clr: assert property (p_db_clr) //RULE8 RULE12
        else $error("doorbell clear word acted wrongly");

    property p_db_read;
        setup && (hit(paddr, bpdi_pkg::OFF_DB_SET)
                  || hit(paddr, bpdi_pkg::OFF_DB_CLEAR))
        |=> prdata == $past(st_r.db);
    endproperty
    a_db_read: assert property (p_db_read) //RULE10 RULE13
        else $error("doorbell read does not match shared bits");

    property p_pri_route;
        $rose(pri_req) && !st_r.rev_s2 && !st_r.msi_s2
        |=> pri_msg_assert ##1 !pri_msg_assert;
    endproperty
    a_pri_route: assert property (p_pri_route) //RULE11
        else $error("primary doorbell not signalled on primary side");

    property p_mask_hi_wr;
        s_wr_to(bpdi_pkg::OFF_PB_MASK_HI)
        |=> st_r.pb_mask_hi == $past(pwdata);
    endproperty
    a_mask_hi_wr: assert property (p_mask_hi_wr) //RULE7
        else $error("upper page mask not written");

    property p_page_hold;
        !page_hit && !(wr && hit(paddr, bpdi_pkg::OFF_PB_REQ_HI))
        |=> $stable(st_r.pb_req_hi);
    endproperty
    a_page_hold: assert property (p_page_hold) //RULE2 RULE12
        else $error("page request bits changed with no event");

    property p_sec_msi;
        $rose(sec_req) && st_r.msi_s2 |=> sec_msi_req && sec_intx_n;
    endproperty
    a_sec_msi: assert property (p_sec_msi) //RULE4 RULE5
        else $error("no secondary MSI pulse on request rise");

    property p_rev_deassert;
        $fell(sec_req) && st_r.rev_s2 && !st_r.msi_s2
        |=> sec_msg_deassert;
    endproperty
    a_rev_deassert: assert property (p_rev_deassert) //RULE5
        else $error("no deassert message in reverse mode");

    property p_pri_pin;
        pri_req && st_r.rev_s2 && !st_r.msi_s2 |=> !pri_intx_n;
    endproperty
    a_pri_pin: assert property (p_pri_pin) //RULE11
        else $error("primary pin not asserted for primary doorbell");

endmodule

// ---- bpdi_host_model.sv ----
/*
 * Far-side model: the bridge datapath that reports finished transfers,
 * and a receiver that counts interrupt message and MSI pulses.
 * Assumes one pclk domain; the bench calls page_done at a rising edge.
 */
`timescale 1ns/100ps
module bpdi_host_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    output logic            xfer_done,
    output logic            xfer_last_dw,
    output logic [6:0]      xfer_page,
    input  wire logic       pri_msg_assert,
    input  wire logic       pri_msg_deassert,
    input  wire logic       pri_msi_req,
    input  wire logic       sec_msg_assert,
    input  wire logic       sec_msg_deassert,
    input  wire logic       sec_msi_req
);
    int n_pri_assert;
    int n_pri_deassert;
    int n_pri_msi;
    int n_sec_assert;
    int n_sec_deassert;
    int n_sec_msi;

    initial begin
        xfer_done    = 1'b0;
        xfer_last_dw = 1'b0;
        xfer_page    = 7'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // One completed transfer, then the page lines go stale
    task automatic page_done(input logic [6:0] pg, input logic last);
        xfer_done    <= 1'b1;
        xfer_last_dw <= last;
        xfer_page    <= pg;
        @(posedge pclk);
        xfer_done    <= 1'b0;
        xfer_last_dw <= ~last;
        xfer_page    <= ~pg;
        @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Pulse counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_pri_assert   <= 0;
            n_pri_deassert <= 0;
            n_pri_msi      <= 0;
            n_sec_assert   <= 0;
            n_sec_deassert <= 0;
            n_sec_msi      <= 0;
        end else begin
            if (pri_msg_assert === 1'b1) n_pri_assert <= n_pri_assert + 1;
            if (pri_msg_deassert === 1'b1) begin
                n_pri_deassert <= n_pri_deassert + 1;
            end
            if (pri_msi_req === 1'b1) n_pri_msi <= n_pri_msi + 1;
            if (sec_msg_deassert === 1'b1) begin
                n_sec_deassert <= n_sec_deassert + 1;
            end
            if (sec_msg_assert === 1'b1) n_sec_assert <= n_sec_assert + 1;
            if (sec_msi_req === 1'b1) n_sec_msi <= n_sec_msi + 1;
        end
    end
endmodule

// ---- test_bridge_page_and_doorbell_irq.sv ----
/*
 * Self-checking bench: APB register accesses, page events and mode pins.
 * Assumes the design and the host model compiled before this file.
 */
`timescale 1ns/100ps
module test_bridge_page_and_doorbell_irq;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        xfer_done;
    logic        xfer_last_dw;
    logic [6:0]  xfer_page;
    logic        bridge_reverse;
    logic        msi_enable;
    logic        pri_intx_n;
    logic        pri_msg_assert;
    logic        pri_msg_deassert;
    logic        pri_msi_req;
    logic        sec_intx_n;
    logic        sec_msg_assert;
    logic        sec_msg_deassert;
    logic        sec_msi_req;
    logic        irq;
    int          errors;
    int          n_checks;
    int          m;
    int          k;

    bpdi_irq_ctrl bpdi_irq_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xfer_done(xfer_done),
        .xfer_last_dw(xfer_last_dw), .xfer_page(xfer_page),
        .bridge_reverse(bridge_reverse), .msi_enable(msi_enable),
        .pri_intx_n(pri_intx_n), .pri_msg_assert(pri_msg_assert),
        .pri_msg_deassert(pri_msg_deassert), .pri_msi_req(pri_msi_req),
        .sec_intx_n(sec_intx_n), .sec_msg_assert(sec_msg_assert),
        .sec_msg_deassert(sec_msg_deassert),
        .sec_msi_req(sec_msi_req), .irq(irq)
    );

    bpdi_host_model bpdi_host_model_inst (
        .pclk(pclk), .presetn(presetn), .xfer_done(xfer_done),
        .xfer_last_dw(xfer_last_dw), .xfer_page(xfer_page),
        .pri_msg_assert(pri_msg_assert),
        .pri_msg_deassert(pri_msg_deassert), .pri_msi_req(pri_msi_req),
        .sec_msg_assert(sec_msg_assert),
        .sec_msg_deassert(sec_msg_deassert), .sec_msi_req(sec_msi_req)
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Verdict, compare and bus tasks
    task automatic close_out();
        if (errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        n = 0;
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n == 50) begin
            errors++;
            close_out();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rdc(input string nm, input logic [11:0] a,
                       input logic [31:0] exp, input logic experr);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h00000000, q, e);
        chk(nm, q, exp);
        chk({nm, " err"}, {31'h0, e}, {31'h0, experr});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        errors = 0;
        n_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        bridge_reverse = 1'b0;
        msi_enable = 1'b0;
        cyc(2);
        presetn <= 1'b1;
        cyc(4);
        rdc("pb_req_hi", 12'h05C, 32'h00000000, 1'b0);
        rdc("mask_lo", 12'h060, 32'h0FFFFFFF, 1'b0);
        rdc("mask_hi", 12'h064, 32'h0FFFFFFF, 1'b0);
        rdc("db_clr", 12'h070, 32'h00000000, 1'b0);
        rdc("db_set", 12'h074, 32'h00000000, 1'b0);
        chk("irq", {31'h0, irq}, 32'h00000000);
        m = bpdi_host_model_inst.n_pri_assert;
        wr(12'h074, 32'h00008001);
        cyc(3);
        rdc("db_set", 12'h074, 32'h00008001, 1'b0);
        rdc("db_clr", 12'h070, 32'h00008001, 1'b0);
        chk("sec_intx_n", {31'h0, sec_intx_n}, 32'h00000001);
        k = bpdi_host_model_inst.n_pri_assert;
        chk("pri_msg", 32'(k), 32'(m + 1));
        chk("irq", {31'h0, irq}, 32'h00000001);
        wr(12'h074, 32'h80000000);
        cyc(3);
        chk("sec_intx_n", {31'h0, sec_intx_n}, 32'h00000000);
        wr(12'h070, 32'h00000000);
        wr(12'h074, 32'h00000000);
        rdc("db_clr", 12'h070, 32'h80008001, 1'b0);
        wr(12'h070, 32'h80000001);
        cyc(3);
        rdc("db_set", 12'h074, 32'h00008000, 1'b0);
        chk("sec_intx_n", {31'h0, sec_intx_n}, 32'h00000001);
        m = bpdi_host_model_inst.n_pri_deassert;
        wr(12'h070, 32'h00008000);
        cyc(3);
        chk("irq", {31'h0, irq}, 32'h00000000);
        k = bpdi_host_model_inst.n_pri_deassert;
        chk("pri_deassert", 32'(k), 32'(m + 1));
        bpdi_host_model_inst.page_done(7'd33, 1'b1);
        bpdi_host_model_inst.page_done(7'd64, 1'b1);
        bpdi_host_model_inst.page_done(7'd32, 1'b1);
        bpdi_host_model_inst.page_done(7'd50, 1'b0);
        cyc(3);
        rdc("pb_req_hi", 12'h05C, 32'h80000001, 1'b0);
        chk("sec_intx_n", {31'h0, sec_intx_n}, 32'h00000000);
        wr(12'h064, 32'hFFFFFFFE);
        cyc(3);
        chk("sec_intx_n", {31'h0, sec_intx_n}, 32'h00000000);
        wr(12'h060, 32'h12345678);
        rdc("mask_lo", 12'h060, 32'h12345678, 1'b0);
        wr(12'h05C, 32'h00000000);
        rdc("pb_req_hi", 12'h05C, 32'h80000001, 1'b0);
        wr(12'h05C, 32'h00000001);
        cyc(3);
        rdc("pb_req_hi", 12'h05C, 32'h80000000, 1'b0);
        chk("sec_intx_n", {31'h0, sec_intx_n}, 32'h00000001);
        wr(12'h05C, 32'h80000000);
        wr(12'h064, 32'h00000000);
        bridge_reverse <= 1'b1;
        cyc(4);
        m = bpdi_host_model_inst.n_sec_assert;
        bpdi_host_model_inst.page_done(7'd40, 1'b1);
        cyc(4);
        k = bpdi_host_model_inst.n_sec_assert;
        chk("sec_msg", 32'(k), 32'(m + 1));
        chk("sec_intx_n", {31'h0, sec_intx_n}, 32'h00000001);
        wr(12'h074, 32'h00000002);
        cyc(3);
        chk("pri_intx_n", {31'h0, pri_intx_n}, 32'h00000000);
        wr(12'h070, 32'h00000002);
        m = bpdi_host_model_inst.n_sec_deassert;
        wr(12'h05C, 32'h00000080);
        msi_enable <= 1'b1;
        cyc(4);
        k = bpdi_host_model_inst.n_sec_deassert;
        chk("sec_deassert", 32'(k), 32'(m + 1));
        chk("pri_intx_n", {31'h0, pri_intx_n}, 32'h00000001);
        m = bpdi_host_model_inst.n_sec_msi;
        bpdi_host_model_inst.page_done(7'd41, 1'b1);
        cyc(4);
        k = bpdi_host_model_inst.n_sec_msi;
        chk("sec_msi", 32'(k), 32'(m + 1));
        m = bpdi_host_model_inst.n_pri_msi;
        wr(12'h074, 32'h00000004);
        cyc(3);
        k = bpdi_host_model_inst.n_pri_msi;
        chk("pri_msi", 32'(k), 32'(m + 1));
        rdc("unmapped", 12'h068, 32'h00000000, 1'b1);
        close_out();
    end
endmodule
